/* File: agen_pkg.sv */
// Purpose: shared constants and types of the operand address generator
// Assumes: 16-bit data space addresses and sixteen working registers
// Notes: modes and instruction classes are one-hot codes
package agen_pkg;
  localparam int ADDR_W = 16;                    // address and register width
  localparam int REG_CNT = 16;                   // working registers
  localparam int SEL_W = 4;                      // register select width
  localparam int LANES = 2;                      // operand lanes (x/src, y/dst)
  localparam int SHORT_LIT_W = 8;                // short literal width
  localparam int HOLD_LIT_W = 14;                // interrupt hold literal width
  localparam logic [SEL_W-1:0] X_PTR_BASE = 4'h8; // first x prefetch pointer
  localparam logic [SEL_W-1:0] Y_PTR_BASE = 4'hA; // first y prefetch pointer
  localparam logic [3:0] DSP_STEP_A = 4'h2;      // dsp post-modify steps
  localparam logic [3:0] DSP_STEP_B = 4'h4;
  localparam logic [3:0] DSP_STEP_C = 4'h6;
  localparam logic [1:0] IMM_NONE = 2'h0;        // no literal operand
  localparam logic [1:0] IMM_LIT8 = 2'h1;        // 8-bit literal operand
  localparam logic [1:0] IMM_LIT16 = 2'h2;       // 16-bit literal operand

  // addressing modes
  typedef enum logic [6:0] {
    AM_FILE = 7'h01,
    AM_REG = 7'h02,
    AM_IND = 7'h04,
    AM_POST = 7'h08,
    AM_PRE = 7'h10,
    AM_IDX = 7'h20,
    AM_LIT = 7'h40
  } addr_mode_t;

  // instruction classes as seen by the address generator
  typedef enum logic [6:0] {
    IC_NORMAL = 7'h01,
    IC_MOVE = 7'h02,
    IC_DSP = 7'h04,
    IC_BRANCH = 7'h08,
    IC_HOLD = 7'h10,
    IC_IMPLIED = 7'h20,
    IC_NOP = 7'h40
  } instr_class_t;

  // decoded instruction fields from the decoder
  typedef struct packed {
    logic valid;
    instr_class_t cls;
    addr_mode_t src_mode;
    addr_mode_t dst_mode;
    logic [SEL_W-1:0] src_sel;
    logic [SEL_W-1:0] dst_sel;
    logic [SEL_W-1:0] idx_sel;
    logic src_dec;
    logic dst_dec;
    logic [3:0] src_step;
    logic [3:0] dst_step;
    logic x_high;
    logic y_high;
    logic [1:0] imm_kind;
    logic [ADDR_W-1:0] literal;
    logic [ADDR_W-1:0] file_addr;
  } decode_t;

  // circular buffer window, upper bound exclusive
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] lower;
    logic [ADDR_W-1:0] upper;
  } modulo_cfg_t;

  // one operand lane
  typedef struct packed {
    logic active;
    addr_mode_t mode;
    logic [SEL_W-1:0] sel;
    logic dec;
    logic [3:0] step;
  } lane_t;

  // external register write port
  typedef struct packed {
    logic en;
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] data;
  } reg_wr_t;

  // whole state of the generator
  typedef struct packed {
    logic [REG_CNT-1:0][ADDR_W-1:0] regs;
    logic [ADDR_W-1:0] x_addr;
    logic x_valid;
    logic [ADDR_W-1:0] y_addr;
    logic y_valid;
    logic [ADDR_W-1:0] reg_data;
    logic reg_valid;
    logic [ADDR_W-1:0] imm;
    logic imm_valid;
    logic implied;
    logic illegal;
  } state_t;

  localparam state_t STATE_RESET = '0;           // everything clear at reset
endpackage

/* File: modulo_wrap.sv */
// Purpose: circular buffer boundary correction of one address
// Assumes: window is lower..upper-1 and a jump is shorter than the window
// Notes: purely combinational
`timescale 1ns/1ps
module modulo_wrap (
  // window and candidate
  input wire agen_pkg::modulo_cfg_t cfg_in,
  input wire logic [agen_pkg::ADDR_W-1:0] addr_in,
  input wire logic dec_in,
  // corrected address
  output logic [agen_pkg::ADDR_W-1:0] addr_out,
  output logic wrapped_out
);
  import agen_pkg::*;

  logic [ADDR_W-1:0] span; // window length

  assign span = cfg_in.upper - cfg_in.lower;

  // compare with ordered bounds (>= upper, < lower) so that long jumps wrap too
  always_comb begin
    addr_out = addr_in;
    wrapped_out = 1'b0;
    if (cfg_in.en && !dec_in && addr_in >= cfg_in.upper) begin
      addr_out = addr_in - span;
      wrapped_out = 1'b1;
    end else if (cfg_in.en && dec_in && addr_in < cfg_in.lower) begin
      addr_out = addr_in + span;
      wrapped_out = 1'b1;
    end
  end
endmodule // modulo_wrap

/* File: operand_address_generation.sv */
// Purpose: effective address generation and pointer update for data operands
// Assumes: decoder presents one decoded instruction per cycle
// Notes: results appear one cycle after the instruction; pointers update together
`timescale 1ns/1ps
// Functional notes
// - file direct uses instruction address field
// - register direct reads register, no address
// - plain indirect uses pointer value unchanged
// - post-modify: old pointer addresses, then step
// - pre-modify: stepped pointer forms the address
// - indexed: pointer plus offset register
// - literal offset: pointer plus instruction literal
// - moves add indexed mode and literals
// - move source and destination modes independent
// - one shared 4-bit offset select
// - dsp pointers limited to eight to eleven
// - pointers eight, nine feed x reads
// - pointers ten, eleven feed y unit
// - dsp indexed only on nine, eleven
// - dsp: indirect, indexed, post-step 2/4/6
// - branch 16-bit signed, hold 14-bit unsigned
// - implied operands and no-operand instructions
// - modulo correction on any working register
// - wrap at or past the upper bound, or below the lower bound
// - corrected value written back on pre/post
// - offset modes correct but keep pointer
module operand_address_generation (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // decoded instruction and side inputs
  input wire agen_pkg::decode_t decode_in,
  input wire agen_pkg::reg_wr_t reg_wr_in,
  input wire agen_pkg::modulo_cfg_t modulo_in,
  // x space or move source operand
  output logic [agen_pkg::ADDR_W-1:0] x_addr_out,
  output logic x_valid_out,
  // y space or move destination operand
  output logic [agen_pkg::ADDR_W-1:0] y_addr_out,
  output logic y_valid_out,
  // register direct operand
  output logic [agen_pkg::ADDR_W-1:0] reg_data_out,
  output logic reg_valid_out,
  // literal operand
  output logic [agen_pkg::ADDR_W-1:0] imm_out,
  output logic imm_valid_out,
  // status
  output logic implied_out,
  output logic illegal_out
);
  import agen_pkg::*;

  state_t st_r; // registered state
  state_t st_nxt; // next state
  lane_t lane_q [LANES]; // lane descriptors
  logic [ADDR_W-1:0] lane_base [LANES]; // pointer value
  logic [ADDR_W-1:0] lane_step [LANES]; // step widened
  logic [ADDR_W-1:0] lane_off [LANES]; // signed offset
  logic [ADDR_W-1:0] lane_sum [LANES]; // pointer plus offset
  logic [ADDR_W-1:0] lane_mod [LANES]; // after modulo correction
  logic [ADDR_W-1:0] lane_ea [LANES]; // effective address
  logic lane_wrap [LANES]; // correction happened
  logic lane_wb [LANES]; // pointer write-back wanted
  logic [ADDR_W-1:0] idx_val; // shared offset register
  logic ok; // instruction legal

  // dsp lane legality
  function automatic logic dsp_ok(input lane_t l, input logic high);
    logic good;
    good = 1'b0;
    case (l.mode)
      AM_IND: good = 1'b1;
      AM_POST: good = (l.step == DSP_STEP_A) || (l.step == DSP_STEP_B) || (l.step == DSP_STEP_C);
      AM_IDX: good = high;
      default: good = 1'b0;
    endcase
    return good;
  endfunction

  assign idx_val = st_r.regs[decode_in.idx_sel];

  // choose lanes from the instruction class
  always_comb begin
    for (int k = 0; k < LANES; k++) begin
      lane_q[k] = '0;
      lane_q[k].mode = AM_IND;
    end
    case (decode_in.cls)
      IC_NORMAL: begin
        lane_q[0] = '{active: decode_in.valid, mode: decode_in.src_mode, sel: decode_in.src_sel,
                      dec: decode_in.src_dec, step: decode_in.src_step};
      end
      IC_MOVE: begin
        // source and destination each bring their own mode
        lane_q[0] = '{active: decode_in.valid && decode_in.imm_kind == IMM_NONE, mode: decode_in.src_mode,
                      sel: decode_in.src_sel, dec: decode_in.src_dec, step: decode_in.src_step};
        lane_q[1] = '{active: decode_in.valid, mode: decode_in.dst_mode, sel: decode_in.dst_sel,
                      dec: decode_in.dst_dec, step: decode_in.dst_step};
      end
      IC_DSP: begin
        // pointer choice is only eight/nine for x and ten/eleven for y
        lane_q[0] = '{active: decode_in.valid, mode: decode_in.src_mode, sel: X_PTR_BASE | {3'h0, decode_in.x_high},
                      dec: decode_in.src_dec, step: decode_in.src_step};
        lane_q[1] = '{active: decode_in.valid, mode: decode_in.dst_mode, sel: Y_PTR_BASE | {3'h0, decode_in.y_high},
                      dec: decode_in.dst_dec, step: decode_in.dst_step};
      end
      default: begin
        // other classes carry no memory operand
      end
    endcase
  end

  // per-lane address arithmetic
  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign lane_base[g] = st_r.regs[lane_q[g].sel];
      assign lane_step[g] = {12'h000, lane_q[g].step};
      // offset by mode: step, index register or literal
      assign lane_off[g] = (lane_q[g].mode == AM_POST || lane_q[g].mode == AM_PRE) ?
                           (lane_q[g].dec ? (16'h0000 - lane_step[g]) : lane_step[g]) :
                           (lane_q[g].mode == AM_IDX) ? idx_val :
                           (lane_q[g].mode == AM_LIT) ? decode_in.literal : 16'h0000;
      assign lane_sum[g] = lane_base[g] + lane_off[g];
      // circular correction applies whichever register is the pointer
      modulo_wrap u_wrap (
        .cfg_in(modulo_in),
        .addr_in(lane_sum[g]),
        .dec_in(lane_off[g][ADDR_W-1]),
        .addr_out(lane_mod[g]),
        .wrapped_out(lane_wrap[g])
      );
      // post-modify and plain indirect address with the old pointer
      assign lane_ea[g] = (lane_q[g].mode == AM_POST || lane_q[g].mode == AM_IND) ? lane_base[g] :
                          (lane_q[g].mode == AM_FILE) ? decode_in.file_addr : lane_mod[g];
      // only pre and post modes write the pointer back
      assign lane_wb[g] = lane_q[g].active && (lane_q[g].mode == AM_POST || lane_q[g].mode == AM_PRE);
    end
  endgenerate

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.x_valid = 1'b0;
    st_nxt.y_valid = 1'b0;
    st_nxt.reg_valid = 1'b0;
    st_nxt.imm_valid = 1'b0;
    st_nxt.implied = 1'b0;
    st_nxt.illegal = 1'b0;
    // legality per class
    case (decode_in.cls)
      IC_NORMAL: ok = (decode_in.src_mode != AM_IDX) && (decode_in.imm_kind == IMM_NONE);
      IC_DSP: ok = dsp_ok(lane_q[0], decode_in.x_high) && dsp_ok(lane_q[1], decode_in.y_high);
      default: ok = 1'b1;
    endcase
    // external result write, pointer updates below take priority
    if (reg_wr_in.en) begin
      st_nxt.regs[reg_wr_in.sel] = reg_wr_in.data;
    end
    if (decode_in.valid && !ok) begin
      st_nxt.illegal = 1'b1;
    end else if (decode_in.valid) begin
      case (decode_in.cls)
        IC_NORMAL, IC_MOVE: begin
          if (decode_in.cls == IC_MOVE && decode_in.imm_kind == IMM_LIT8) begin
            st_nxt.imm = {8'h00, decode_in.literal[SHORT_LIT_W-1:0]};
            st_nxt.imm_valid = 1'b1;
          end else if (decode_in.cls == IC_MOVE && decode_in.imm_kind == IMM_LIT16) begin
            st_nxt.imm = decode_in.literal;
            st_nxt.imm_valid = 1'b1;
          end else if (lane_q[0].mode == AM_REG) begin
            st_nxt.reg_data = lane_base[0];
            st_nxt.reg_valid = 1'b1;
          end else begin
            st_nxt.x_addr = lane_ea[0];
            st_nxt.x_valid = 1'b1;
          end
          // register destination needs no address
          if (decode_in.cls == IC_MOVE && lane_q[1].mode != AM_REG) begin
            st_nxt.y_addr = lane_ea[1];
            st_nxt.y_valid = 1'b1;
          end
        end
        IC_DSP: begin
          st_nxt.x_addr = lane_ea[0];
          st_nxt.x_valid = 1'b1;
          st_nxt.y_addr = lane_ea[1];
          st_nxt.y_valid = 1'b1;
        end
        IC_BRANCH: begin
          st_nxt.imm = decode_in.literal;
          st_nxt.imm_valid = 1'b1;
        end
        IC_HOLD: begin
          st_nxt.imm = {2'h0, decode_in.literal[HOLD_LIT_W-1:0]};
          st_nxt.imm_valid = 1'b1;
        end
        IC_IMPLIED: begin
          st_nxt.implied = 1'b1;
        end
        default: begin
          // no-operation: nothing addressed
        end
      endcase
      // pointer updates land with the address, destination last
      for (int i = 0; i < LANES; i++) begin
        if (lane_wb[i]) begin
          st_nxt.regs[lane_q[i].sel] = lane_mod[i];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign x_addr_out = st_r.x_addr;
  assign x_valid_out = st_r.x_valid;
  assign y_addr_out = st_r.y_addr;
  assign y_valid_out = st_r.y_valid;
  assign reg_data_out = st_r.reg_data;
  assign reg_valid_out = st_r.reg_valid;
  assign imm_out = st_r.imm;
  assign imm_valid_out = st_r.imm_valid;
  assign implied_out = st_r.implied;
  assign illegal_out = st_r.illegal;

  // file direct address is the instruction field
  property p_file_direct;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_NORMAL && decode_in.src_mode == AM_FILE && decode_in.imm_kind == IMM_NONE)
    |=> (x_valid_out && x_addr_out == $past(decode_in.file_addr));
  endproperty
  a_file_direct: assert property (p_file_direct) else $error("file direct address wrong");

  // register direct gives data and no address
  property p_reg_direct;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_NORMAL && decode_in.src_mode == AM_REG && decode_in.imm_kind == IMM_NONE)
    |=> (reg_valid_out && !x_valid_out && reg_data_out == $past(lane_base[0]));
  endproperty
  a_reg_direct: assert property (p_reg_direct) else $error("register direct operand wrong");

  // post-modify addresses with old pointer and stores the stepped pointer
  property p_post_mod;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_NORMAL && decode_in.src_mode == AM_POST && decode_in.imm_kind == IMM_NONE)
    |=> (x_addr_out == $past(lane_base[0]) && st_r.regs[$past(decode_in.src_sel)] == $past(lane_mod[0]));
  endproperty
  a_post_mod: assert property (p_post_mod) else $error("post-modify wrong");

  // pre-modify addresses with stepped pointer
  property p_pre_mod;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_NORMAL && decode_in.src_mode == AM_PRE && decode_in.imm_kind == IMM_NONE)
    |=> (x_addr_out == $past(lane_mod[0]) && st_r.regs[$past(decode_in.src_sel)] == x_addr_out);
  endproperty
  a_pre_mod: assert property (p_pre_mod) else $error("pre-modify wrong");

  // indexed move leaves every register as it was
  property p_idx_keep;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_MOVE && decode_in.src_mode == AM_IDX && decode_in.dst_mode == AM_IND &&
     decode_in.imm_kind == IMM_NONE && !reg_wr_in.en)
    |=> (st_r.regs == $past(st_r.regs) && x_addr_out == $past(lane_mod[0]));
  endproperty
  a_idx_keep: assert property (p_idx_keep) else $error("indexed mode changed a pointer");

  // dsp indexed on the first pointer of a pair is refused
  property p_dsp_idx;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_DSP && decode_in.src_mode == AM_IDX && !decode_in.x_high)
    |=> (illegal_out && !x_valid_out && !y_valid_out);
  endproperty
  a_dsp_idx: assert property (p_dsp_idx) else $error("dsp indexed on wrong pointer accepted");

  // ordinary instructions refuse indexed mode
  property p_normal_idx;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_NORMAL && decode_in.src_mode == AM_IDX) |=> illegal_out;
  endproperty
  a_normal_idx: assert property (p_normal_idx) else $error("indexed mode accepted on ordinary instruction");

  // hold literal is unsigned 14 bits
  property p_hold_lit;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_HOLD)
    |=> (imm_valid_out && imm_out[15:14] == 2'h0 && imm_out[13:0] == $past(decode_in.literal[13:0]));
  endproperty
  a_hold_lit: assert property (p_hold_lit) else $error("hold literal wrong");

  // no-operation produces nothing
  property p_nop;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_NOP)
    |=> !(x_valid_out || y_valid_out || reg_valid_out || imm_valid_out || implied_out || illegal_out);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation produced an operand");

  // incrementing pre-modify past the upper bound wraps by the window length
  property p_wrap_up;
    @(posedge clock_in) disable iff (sys_rst_in)
    (decode_in.valid && decode_in.cls == IC_NORMAL && decode_in.src_mode == AM_PRE && !decode_in.src_dec &&
     decode_in.imm_kind == IMM_NONE && modulo_in.en && lane_sum[0] >= modulo_in.upper)
    |=> ($past(lane_wrap[0]) &&
         x_addr_out == 16'($past(lane_sum[0]) - ($past(modulo_in.upper) - $past(modulo_in.lower))));
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("upper boundary not wrapped");
endmodule // operand_address_generation

/* File: instr_feed_model.sv */
// Purpose: instruction feed standing in for the decoder side
// Assumes: one decoded instruction per call, driven 1 ns after the edge
// Notes: idle cycles carry inverted stale fields so nothing leans on them
`timescale 1ns/1ps
module instr_feed_model (
  // clock
  input wire logic clock_in,
  // decoded instruction
  output agen_pkg::decode_t decode_out
);
  import agen_pkg::*;
  decode_t last; // last value put on the bus
  // bus starts idle
  initial begin
    decode_out = '0;
    last = '0;
  end
  // offer one instruction for the next edge
  task automatic put(input decode_t d);
    @(posedge clock_in);
    #1;
    last = d;
    decode_out = last;
  endtask
  // no instruction: fields flip so stale values are never seen
  task automatic idle();
    @(posedge clock_in);
    #1;
    last = ~last;
    last.valid = 1'b0;
    decode_out = last;
  endtask
endmodule // instr_feed_model

/* File: operand_address_generation_bench.sv */
// Purpose: self-checking bench of the operand address generator
// Assumes: results pulse one cycle after the instruction is taken
// Notes: a shadow register file here predicts addresses and pointer updates
`timescale 1ns/1ps
module operand_address_generation_bench;
  import agen_pkg::*;
  // one instruction's expected results
  typedef struct packed {
    logic xv; logic [15:0] xa; logic yv; logic [15:0] ya; logic rv; logic [15:0] rd;
    logic iv; logic [15:0] im; logic impl; logic ill;
  } expect_t;
  logic clock_in, sys_rst_in;
  decode_t decode_in;
  reg_wr_t reg_wr_in;
  modulo_cfg_t modulo_in;
  logic [15:0] x_addr_out, y_addr_out, reg_data_out, imm_out;
  logic x_valid_out, y_valid_out, reg_valid_out, imm_valid_out, implied_out, illegal_out;
  int errors, checks;
  logic [15:0] seed = 16'h004F; // lfsr state, starts at 79
  logic [15:0] sh [16]; // shadow working registers
  expect_t ex; // results due at the coming edge
  logic mod_small; // keep literals short while wrapping is on
  addr_mode_t nm [6] = '{AM_FILE, AM_REG, AM_IND, AM_POST, AM_PRE, AM_LIT};
  addr_mode_t mm [7] = '{AM_FILE, AM_REG, AM_IND, AM_POST, AM_PRE, AM_IDX, AM_LIT};
  addr_mode_t dm [3] = '{AM_IND, AM_POST, AM_IDX};
  logic [3:0] dstep [3] = '{DSP_STEP_A, DSP_STEP_B, DSP_STEP_C};
  // 10 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  operand_address_generation uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .decode_in(decode_in),
    .reg_wr_in(reg_wr_in), .modulo_in(modulo_in), .x_addr_out(x_addr_out), .x_valid_out(x_valid_out),
    .y_addr_out(y_addr_out), .y_valid_out(y_valid_out), .reg_data_out(reg_data_out),
    .reg_valid_out(reg_valid_out), .imm_out(imm_out), .imm_valid_out(imm_valid_out),
    .implied_out(implied_out), .illegal_out(illegal_out));
  instr_feed_model feed (.clock_in(clock_in), .decode_out(decode_in));
  // next pseudo random word
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // circular window correction of a candidate address
  function automatic logic [15:0] wrapa(logic [15:0] a, logic [15:0] o);
    if (modulo_in.en && !o[15] && a >= modulo_in.upper) return a - (modulo_in.upper - modulo_in.lower);
    if (modulo_in.en && o[15] && a < modulo_in.lower) return a + (modulo_in.upper - modulo_in.lower);
    return a;
  endfunction
  // dsp lane legality
  function automatic logic dsp_ok(addr_mode_t m, logic [3:0] st, logic hi);
    return m == AM_IND || (m == AM_POST && (st == 4'h2 || st == 4'h4 || st == 4'h6)) || (m == AM_IDX && hi);
  endfunction
  // compare and count
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // address and pointer update of one lane, from old register values
  task automatic lane(input addr_mode_t m, input logic [3:0] s, input logic dn, input logic [3:0] st,
                      input decode_t d, output logic [15:0] a, output logic up, output logic [15:0] nv);
    logic [15:0] p;
    logic [15:0] o;
    p = sh[s];
    o = dn ? -{12'h000, st} : {12'h000, st};
    up = m == AM_POST || m == AM_PRE;
    nv = wrapa(p + o, o);
    case (m)
      AM_FILE: a = d.file_addr;
      AM_POST: a = p;
      AM_PRE: a = nv;
      AM_IDX: a = wrapa(p + sh[d.idx_sel], sh[d.idx_sel]);
      AM_LIT: a = wrapa(p + d.literal, d.literal);
      default: a = p;
    endcase
  endtask
  // work out results of an instruction and update the shadow
  task automatic predict(input decode_t d);
    logic [15:0] a0, a1, n0, n1;
    logic u0, u1, ok;
    logic [3:0] s0, s1;
    ex = '0;
    if (!d.valid) return;
    s0 = d.cls == IC_DSP ? {3'b100, d.x_high} : d.src_sel;
    s1 = d.cls == IC_DSP ? {3'b101, d.y_high} : d.dst_sel;
    lane(d.src_mode, s0, d.src_dec, d.src_step, d, a0, u0, n0);
    lane(d.dst_mode, s1, d.dst_dec, d.dst_step, d, a1, u1, n1);
    ex.xa = a0;
    ex.ya = a1;
    ex.rd = sh[s0];
    ok = 1'b0;
    case (d.cls)
      IC_NORMAL: begin
        ok = d.src_mode != AM_IDX && d.imm_kind == IMM_NONE;
        ex.rv = ok && d.src_mode == AM_REG;
        ex.xv = ok && d.src_mode != AM_REG;
        u1 = 1'b0;
      end
      IC_MOVE: begin
        ex.iv = d.imm_kind != IMM_NONE;
        ex.im = d.imm_kind == IMM_LIT8 ? {8'h00, d.literal[7:0]} : d.literal;
        ok = !ex.iv;
        ex.rv = ok && d.src_mode == AM_REG;
        ex.xv = ok && d.src_mode != AM_REG;
        ex.yv = d.dst_mode != AM_REG;
        u1 = u1 && ex.yv;
      end
      IC_DSP: begin
        ok = dsp_ok(d.src_mode, d.src_step, d.x_high) && dsp_ok(d.dst_mode, d.dst_step, d.y_high);
        ex.xv = ok;
        ex.yv = ok;
        u1 = u1 && ok;
      end
      IC_BRANCH: {ex.iv, ex.im} = {1'b1, d.literal};
      IC_HOLD: {ex.iv, ex.im} = {1'b1, 2'b00, d.literal[13:0]};
      IC_IMPLIED: ex.impl = 1'b1;
      default: u1 = 1'b0;
    endcase
    ex.ill = (d.cls == IC_NORMAL || d.cls == IC_DSP) && !ok;
    if (ok && u0) sh[s0] = n0;
    if (d.cls inside {IC_NORMAL, IC_MOVE, IC_DSP} && u1) sh[s1] = n1;
  endtask
  // offer one instruction (or idle), check the results due now
  task automatic step(input decode_t d, input reg_wr_t w);
    if (d.valid) feed.put(d);
    else feed.idle();
    reg_wr_in = w;
    chk("x_valid", 16'(ex.xv), 16'(x_valid_out));
    if (ex.xv) chk("x_addr", ex.xa, x_addr_out);
    chk("y_valid", 16'(ex.yv), 16'(y_valid_out));
    if (ex.yv) chk("y_addr", ex.ya, y_addr_out);
    chk("reg_valid", 16'(ex.rv), 16'(reg_valid_out));
    if (ex.rv) chk("reg_data", ex.rd, reg_data_out);
    chk("imm_valid", 16'(ex.iv), 16'(imm_valid_out));
    if (ex.iv) chk("imm", ex.im, imm_out);
    chk("implied", 16'(ex.impl), 16'(implied_out));
    chk("illegal", 16'(ex.ill), 16'(illegal_out));
    predict(d);
    if (w.en) sh[w.sel] = w.data;
  endtask
  // random instruction of a class
  function automatic decode_t gen(instr_class_t c);
    decode_t d;
    logic [15:0] r, q, l;
    r = rnd();
    q = rnd();
    l = rnd();
    d = '0;
    d.valid = 1'b1;
    d.cls = c;
    d.src_sel = 4'h4 + r[3:0] % 4'hC;
    d.dst_sel = 4'h4 + r[7:4] % 4'hC;
    d.idx_sel = {2'b00, r[9:8]};
    d.src_dec = r[10];
    d.dst_dec = r[11];
    d.src_step = r[15:12];
    d.dst_step = q[3:0];
    d.literal = mod_small ? {{11{q[15]}}, q[8:4]} : l;
    d.file_addr = l ^ q;
    d.src_mode = nm[q[11:9] % 3'h6];
    d.dst_mode = AM_REG;
    if (c == IC_MOVE) begin
      d.src_mode = mm[q[11:9] % 3'h7];
      d.dst_mode = mm[q[14:12] % 3'h7];
      d.imm_kind = q[1:0] == 2'h3 ? IMM_LIT8 : (q[1:0] == 2'h2 ? IMM_LIT16 : IMM_NONE);
    end
    if (c == IC_DSP) begin
      d.src_mode = dm[q[5:4] % 2'h3];
      d.dst_mode = dm[q[7:6] % 2'h3];
      d.src_step = dstep[r[13:12] % 2'h3];
      d.dst_step = dstep[q[1:0] % 2'h3];
      {d.src_dec, d.dst_dec} = 2'b00;
      d.x_high = r[14] | (d.src_mode == AM_IDX);
      d.y_high = r[15] | (d.dst_mode == AM_IDX);
    end
    return d;
  endfunction
  // random run of one class with idle gaps
  task automatic run(input string name, input instr_class_t c, input int n);
    logic [15:0] r;
    for (int i = 0; i < n; i++) begin
      step(gen(c), '0);
      r = rnd();
      if (r[0]) step('0, '0);
    end
    $display("test %s done, errors %0d", name, errors);
  endtask
  // fill the registers: four small offsets, then pointers
  task automatic load(input logic win);
    reg_wr_t w;
    for (int i = 0; i < 16; i++) begin
      w.en = 1'b1;
      w.sel = 4'(i);
      w.data = i < 4 ? rnd() & 16'h000F : (win ? 16'h1000 | (rnd() & 16'h003E) : rnd());
      step('0, w);
    end
    step('0, '0);
  endtask
  // refused forms, then the same pointer stepped back to back
  task automatic corners();
    decode_t d;
    for (int k = 0; k < 8; k++) begin
      d = gen(k < 2 || k > 5 ? IC_NORMAL : IC_DSP);
      case (k)
        0: d.src_mode = AM_IDX;
        1: d.imm_kind = IMM_LIT8;
        2: begin
          d.src_mode = AM_POST;
          d.src_step = 4'h3;
        end
        3: begin
          d.src_mode = AM_IDX;
          d.x_high = 1'b0;
        end
        4: begin
          d.dst_mode = AM_IDX;
          d.y_high = 1'b0;
        end
        5: d.dst_mode = AM_PRE;
        default: begin
          d.src_mode = AM_POST;
          d.src_sel = 4'h5;
        end
      endcase
      step(d, '0);
    end
    $display("test corners done, errors %0d", errors);
  endtask
  // verdict
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run of about 640 cycles
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {reg_wr_in, modulo_in, ex, mod_small, errors, checks} = '0;
    sys_rst_in = 1'b1;
    for (int i = 0; i < 16; i++) sh[i] = 16'h0000;
    repeat (10) @(posedge clock_in);
    #1 sys_rst_in = 1'b0;
    run("reset_state", IC_NORMAL, 4);
    load(1'b0);
    run("normal", IC_NORMAL, 60);
    run("move", IC_MOVE, 60);
    run("dsp", IC_DSP, 60);
    corners();
    run("branch", IC_BRANCH, 8);
    run("hold", IC_HOLD, 8);
    run("implied", IC_IMPLIED, 4);
    run("nop", IC_NOP, 4);
    modulo_in = '{1'b1, 16'h1000, 16'h1040};
    mod_small = 1'b1;
    load(1'b1);
    run("wrap_normal", IC_NORMAL, 80);
    run("wrap_move", IC_MOVE, 60);
    run("wrap_dsp", IC_DSP, 40);
    step('0, '0);
    report_and_stop();
  end
endmodule // operand_address_generation_bench
